// [rtl/frx_defines.vh]
`ifndef FRX_DEFINES_VH
`define FRX_DEFINES_VH

// Five-bit code-groups, sent oldest bit in bit 4
`define FRX_SYM_W       5
`define FRX_NIB_W       4
`define FRX_CG_IDLE     5'h1F
`define FRX_CG_J        5'h18
`define FRX_CG_K        5'h11
`define FRX_CG_T        5'h0D
`define FRX_CG_R        5'h07
`define FRX_CG_JK       10'h311
`define FRX_NIB_PRE     4'h5
`define FRX_NIB_BAD     4'hE
`define FRX_NIB_ZERO    4'h0

// Descrambler key register and its taps
`define FRX_KEY_W       11
`define FRX_TAP_A       10
`define FRX_TAP_B       8
`define FRX_LOCK_GROUPS 4'hC
`define FRX_IDLE_BITS   7'h3A
`define FRX_RUN_MAX     7'h7F

// Times in microseconds and the clock rate
`define FRX_CLK_MHZ     25
`define FRX_HOLD_US     722
`define FRX_LINK_US     395

// FIFO entry: {crs, dv, er, nibble}
`define FRX_ENT_W       7
`define FRX_ENT_CRS     6
`define FRX_ENT_DV      5
`define FRX_ENT_ER      4
`define FRX_FIFO_DEPTH  8
`define FRX_CNT_W       16

`endif

// [rtl/frx_pcs.v]
`include "frx_defines.vh"

module frx_fifo #(
    parameter W     = `FRX_ENT_W,
    parameter DEPTH = `FRX_FIFO_DEPTH,
    parameter AW    = 3
) (
    input  wire         i_clk,    // Clock
    input  wire         i_rst_n,  // Synchronised reset, active low
    input  wire         i_ce,     // Clock enable
    input  wire         i_valid,  // Write request
    output wire         o_ready,  // Not full
    input  wire [W-1:0] i_data,   // Write data
    output wire         o_valid,  // Not empty
    input  wire         i_ready,  // Read accept
    output wire [W-1:0] o_data    // Head entry
);
    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0]   cnt_q;
    wire         push;
    wire         pop;

    assign o_ready = (cnt_q != DEPTH[AW:0]);
    assign o_valid = (cnt_q != {(AW+1){1'b0}});
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;
    assign o_data  = mem[rp_q];

    always @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wp_q] <= i_data;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (push) begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// Summary of operation
// - Line bits gathered into five-bit symbols
// - Frame delivered as four-bit MII nibbles
// - Descramble by XOR with key, idle-based lock
// - Lock after twelve consecutive idle code-groups
// - Lock starts a 722 us hold countdown
// - 58 idle bit times restart the countdown
// - Hold expiry drops lock and resyncs
// - Alignment fed by descrambler or bypass path
// - J/K pair fixes the symbol boundary
// - J/K becomes 0101 0101, then table decode
// - Decode stops on T/R or two idles
// - Link up after 395 us signal detect
// - Link pulses never count as signal detect
// - Idle to non-idle without J/K is bad
// - Bad start gives error and 1110 nibbles
// - Each bad start bumps false carrier count, which saturates at all ones
// - Two idles end error and carrier sense
// - Fiber mode from strap or management write
// - Control codes inside data flag an error
// - End delimiter is 01101 then 00111
// - Key from closed-loop 11-bit LFSR
// - Fiber mode bypasses the descrambler
module frx_pcs #(
    parameter HOLD_CYC = `FRX_HOLD_US * `FRX_CLK_MHZ,
    parameter LINK_CYC = `FRX_LINK_US * `FRX_CLK_MHZ
) (
    input  wire                  i_clk,          // 25 MHz symbol clock
    input  wire                  i_reset_n,      // Async reset, active low
    input  wire                  i_ce,           // Clock enable
    input  wire [`FRX_SYM_W-1:0] i_rx_bits,      // Five NRZ line bits
    input  wire                  i_sig_det,      // Signal detect level
    input  wire                  i_fiber_strap,  // Fiber strap pin
    input  wire                  i_fiber_wr,     // Management write pulse
    input  wire                  i_fiber_wdata,  // Fiber mode value
    input  wire                  i_mii_ready,    // MII side takes nibble
    output reg  [`FRX_NIB_W-1:0] o_rxd,          // Receive nibble
    output reg                   o_rx_dv,        // Receive data valid
    output reg                   o_rx_er,        // Receive error
    output reg                   o_crs,          // Carrier sense
    output wire                  o_fifo_ready,   // Buffer has room
    output reg                   o_link_up,      // Link monitor state
    output reg                   o_locked,       // Descrambler lock
    output reg                   o_fiber_mode,   // Fiber mode active
    output reg  [`FRX_CNT_W-1:0] o_false_carrier_event_counter // Count
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RX   = 3'b010;
    localparam ST_BAD  = 3'b100;

    reg                   rst_m_q;
    reg                   rst_n;
    reg [`FRX_SYM_W-1:0]  bits_m_q;
    reg [`FRX_SYM_W-1:0]  bits_q;
    reg [2:0]             sdet_m_q;
    reg [2:0]             sdet_q;
    reg [2:0]             strap_done_q;
    reg [15:0]            link_cnt_q;
    reg [`FRX_KEY_W-1:0]  key_q;
    reg [`FRX_KEY_W-1:0]  key_d;
    reg [3:0]             lock_cnt_q;
    reg [15:0]            hold_cnt_q;
    reg [6:0]             run_q;
    reg [6:0]             run_d;
    reg                   match;
    reg                   pb;
    reg [`FRX_SYM_W-1:0]  ds;
    reg [`FRX_SYM_W-1:0]  p1_q;
    reg [`FRX_SYM_W-1:0]  p2_q;
    reg [`FRX_SYM_W-1:0]  p3_q;
    reg [`FRX_SYM_W-1:0]  symd_q;
    reg [2:0]             off_q;
    reg [2:0]             jo;
    reg                   jk;
    reg [2:0]             st_q;
    reg                   first_q;
    reg                   wr_en;
    reg [`FRX_ENT_W-1:0]  wr_data;
    reg [`FRX_NIB_W:0]    dec;
    integer               i;
    integer               j;
    wire [`FRX_SYM_W-1:0] ua;
    wire [14:0]           hist;
    wire [9:0]            win;
    wire [`FRX_SYM_W-1:0] sym;
    wire                  act;
    wire                  f_valid;
    wire [`FRX_ENT_W-1:0] f_data;
    wire                  bad_ssd;
    wire                  end_pair;

    function [`FRX_NIB_W:0] f_dec;
        input [`FRX_SYM_W-1:0] s;
        begin
            case (s)
                5'h1E:   f_dec = 5'h00;
                5'h09:   f_dec = 5'h01;
                5'h14:   f_dec = 5'h02;
                5'h15:   f_dec = 5'h03;
                5'h0A:   f_dec = 5'h04;
                5'h0B:   f_dec = 5'h05;
                5'h0E:   f_dec = 5'h06;
                5'h0F:   f_dec = 5'h07;
                5'h12:   f_dec = 5'h08;
                5'h13:   f_dec = 5'h09;
                5'h16:   f_dec = 5'h0A;
                5'h17:   f_dec = 5'h0B;
                5'h1A:   f_dec = 5'h0C;
                5'h1B:   f_dec = 5'h0D;
                5'h1C:   f_dec = 5'h0E;
                5'h1D:   f_dec = 5'h0F;
                default: f_dec = {1'b1, `FRX_NIB_ZERO};
            endcase
        end
    endfunction

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // Line bits, signal detect and strap cross two flops before any logic looks at them
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_m_q <= `FRX_CG_IDLE;
            bits_q   <= `FRX_CG_IDLE;
            sdet_m_q <= 3'h0;
            sdet_q   <= 3'h0;
        end else if (i_ce) begin
            bits_m_q <= i_rx_bits;
            bits_q   <= bits_m_q;
            sdet_m_q <= {i_fiber_wdata, i_fiber_strap, i_sig_det};
            sdet_q   <= sdet_m_q;
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 3'h0;
            o_fiber_mode <= 1'b0;
        end else if (i_ce) begin
            if (!strap_done_q[2]) begin
                strap_done_q <= {strap_done_q[1:0], 1'b1};
                o_fiber_mode <= sdet_q[1];
            end else if (i_fiber_wr) begin
                o_fiber_mode <= i_fiber_wdata;
            end
        end
    end

    // Analog front end keeps link pulses off signal detect
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_cnt_q <= 16'h0000;
            o_link_up  <= 1'b0;
        end else if (i_ce) begin
            if (!sdet_q[0]) begin
                link_cnt_q <= 16'h0000;
                o_link_up  <= 1'b0;
            end else if (link_cnt_q >= LINK_CYC[15:0] - 1'b1) begin
                o_link_up  <= 1'b1;
            end else begin
                link_cnt_q <= link_cnt_q + 1'b1;
            end
        end
    end

    // Bit 4 is the oldest line bit; key advances once per bit
    always @* begin
        key_d = key_q;
        match = 1'b1;
        ds    = `FRX_CG_IDLE;
        run_d = run_q;
        pb    = 1'b0;
        for (i = `FRX_SYM_W - 1; i >= 0; i = i - 1) begin
            pb = key_d[`FRX_TAP_A] ^ key_d[`FRX_TAP_B];
            if (o_locked) begin
                ds[i] = bits_q[i] ^ pb;
                key_d = {key_d[`FRX_KEY_W-2:0], pb};
            end else begin
                match = match & (pb == ~bits_q[i]);
                key_d = {key_d[`FRX_KEY_W-2:0], ~bits_q[i]};
            end
            if (ds[i] && run_d != `FRX_RUN_MAX) begin
                run_d = run_d + 1'b1;
            end else if (!ds[i]) begin
                run_d = 7'h00;
            end
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_q      <= {`FRX_KEY_W{1'b0}};
            lock_cnt_q <= 4'h0;
            hold_cnt_q <= 16'h0000;
            run_q      <= 7'h00;
            o_locked   <= 1'b0;
        end else if (i_ce) begin
            key_q <= key_d;
            run_q <= run_d;
            if (!o_link_up || o_fiber_mode) begin
                lock_cnt_q <= 4'h0;
                o_locked   <= 1'b0;
            end else if (!o_locked) begin
                lock_cnt_q <= match ? lock_cnt_q + 1'b1 : 4'h0;
                if (match && lock_cnt_q == `FRX_LOCK_GROUPS - 1'b1) begin
                    o_locked   <= 1'b1;
                    hold_cnt_q <= HOLD_CYC[15:0];
                end
            end else if (run_d >= `FRX_IDLE_BITS) begin
                hold_cnt_q <= HOLD_CYC[15:0];
            end else if (hold_cnt_q == 16'h0001) begin
                o_locked   <= 1'b0;
                lock_cnt_q <= 4'h0;
                key_q      <= {`FRX_KEY_W{1'b0}};
            end else begin
                hold_cnt_q <= hold_cnt_q - 1'b1;
            end
        end
    end

    assign ua   = o_fiber_mode ? bits_q : ds;
    assign hist = {p2_q, p1_q, ua};
    assign win  = {p1_q, ua};
    assign sym  = win[9 - off_q -: `FRX_SYM_W];
    assign act  = o_link_up && (o_fiber_mode || o_locked);
    assign bad_ssd  = p3_q == `FRX_CG_IDLE && p2_q != `FRX_CG_IDLE
                      && !jk;
    assign end_pair = !first_q && ((symd_q == `FRX_CG_T
                      && sym == `FRX_CG_R)
                      || (symd_q == `FRX_CG_IDLE
                      && sym == `FRX_CG_IDLE));

    always @* begin
        jk = 1'b0;
        jo = 3'h0;
        for (j = `FRX_SYM_W - 1; j >= 0; j = j - 1) begin
            if (hist[14 - j -: 10] == `FRX_CG_JK) begin
                jk = 1'b1;
                jo = j[2:0];
            end
        end
    end

    always @* begin
        dec     = f_dec(symd_q);
        wr_en   = 1'b0;
        wr_data = {`FRX_ENT_W{1'b0}};
        case (st_q)
            ST_IDLE: begin
                if (act && jk) begin
                    wr_en   = 1'b1;
                    wr_data = {3'b110, `FRX_NIB_PRE};
                end else if (act && bad_ssd) begin
                    wr_en   = 1'b1;
                    wr_data = {3'b101, `FRX_NIB_BAD};
                end
            end
            ST_RX: begin
                wr_en = act && !end_pair;
                if (first_q) begin
                    wr_data = {3'b110, `FRX_NIB_PRE};
                end else begin
                    wr_data = {2'b11, dec};
                end
            end
            ST_BAD: begin
                wr_en   = act && !(p1_q == `FRX_CG_IDLE
                          && p2_q == `FRX_CG_IDLE);
                wr_data = {3'b101, `FRX_NIB_BAD};
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // A full buffer drops nibbles; o_fifo_ready lets the system see it
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_q    <= `FRX_CG_IDLE;
            p2_q    <= `FRX_CG_IDLE;
            p3_q    <= `FRX_CG_IDLE;
            symd_q  <= `FRX_CG_IDLE;
            off_q   <= 3'h0;
            st_q    <= ST_IDLE;
            first_q <= 1'b0;
            o_false_carrier_event_counter <= {`FRX_CNT_W{1'b0}};
        end else if (i_ce) begin
            p1_q    <= ua;
            p2_q    <= p1_q;
            p3_q    <= p2_q;
            symd_q  <= sym;
            first_q <= 1'b0;
            if (!act) begin
                st_q  <= ST_IDLE;
                off_q <= 3'h0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        if (jk) begin
                            off_q   <= jo;
                            first_q <= 1'b1;
                            st_q    <= ST_RX;
                        end else if (bad_ssd) begin
                            st_q <= ST_BAD;
                            if (~&o_false_carrier_event_counter) begin
                                o_false_carrier_event_counter <=
                                    o_false_carrier_event_counter
                                    + 1'b1;
                            end
                        end
                    end
                    ST_RX: begin
                        if (end_pair) begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_BAD: begin
                        if (!wr_en) begin
                            st_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    frx_fifo #(
        .W     (`FRX_ENT_W),
        .DEPTH (`FRX_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ce    (i_ce),
        .i_valid (wr_en),
        .o_ready (o_fifo_ready),
        .i_data  (wr_data),
        .o_valid (f_valid),
        .i_ready (i_mii_ready),
        .o_data  (f_data)
    );

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rxd   <= `FRX_NIB_ZERO;
            o_rx_dv <= 1'b0;
            o_rx_er <= 1'b0;
            o_crs   <= 1'b0;
        end else if (i_ce && i_mii_ready) begin
            o_rxd   <= f_valid ? f_data[`FRX_NIB_W-1:0] : `FRX_NIB_ZERO;
            o_rx_dv <= f_valid & f_data[`FRX_ENT_DV];
            o_rx_er <= f_valid & f_data[`FRX_ENT_ER];
            o_crs   <= f_valid & f_data[`FRX_ENT_CRS];
        end
    end
endmodule

// [verif/frx_mii_sink.sv]
module frx_mii_sink (
    input  wire       i_clk,       // Receive clock
    input  wire       i_reset_n,   // Reset, active low
    input  wire       i_stall,     // Hold off the receive side
    input  wire [3:0] i_rxd,       // Receive nibble
    input  wire       i_rx_dv,     // Data valid
    input  wire       i_rx_er,     // Receive error
    input  wire       i_crs,       // Carrier sense
    output logic      o_mii_ready  // Takes one entry per cycle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] got_q[$];
    logic       took_q = 1'b0;
    initial o_mii_ready = 1'b0;
    // Outputs load at an edge with ready high, so they are read one edge on
    always @(posedge i_clk) begin
        if (took_q && (i_crs || i_rx_dv || i_rx_er)) begin
            got_q.push_back({i_crs, i_rx_dv, i_rx_er, i_rxd});
        end
        took_q <= o_mii_ready && i_reset_n;
    end
    always @(negedge i_clk) begin
        o_mii_ready <= ~i_stall;
    end
endmodule

// [verif/frx_pcs_sva.sv]
`include "frx_defines.vh"
module frx_pcs_sva #(
    parameter HOLD_CYC = 200,
    parameter LINK_CYC = 50
) (
    input wire                  i_clk,
    input wire                  i_reset_n,
    input wire                  i_sig_det,
    input wire                  i_fiber_wr,
    input wire                  i_fiber_wdata,
    input wire                  i_mii_ready,
    input wire [`FRX_NIB_W-1:0] o_rxd,
    input wire                  o_rx_dv,
    input wire                  o_rx_er,
    input wire                  o_crs,
    input wire                  o_fifo_ready,
    input wire                  o_link_up,
    input wire                  o_locked,
    input wire                  o_fiber_mode,
    input wire [`FRX_CNT_W-1:0] o_false_carrier_event_counter
);
    timeunit 1ns;
    timeprecision 100ps;
    // Raw run of signal detect; the design sees it a few edges late
    reg [15:0] sd_run_q;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sd_run_q <= 16'h0000;
        end else if (!i_sig_det) begin
            sd_run_q <= 16'h0000;
        end else if (sd_run_q != 16'hFFFF) begin
            sd_run_q <= sd_run_q + 16'h0001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    fc_step_a: assert property (
        $changed(o_false_carrier_event_counter) |->
        o_false_carrier_event_counter ==
        $past(o_false_carrier_event_counter) + 16'h0001)
        else $error("false carrier count moved by other than one");
    fc_cause_a: assert property (
        $changed(o_false_carrier_event_counter) |->
        ##[0:20] (o_rx_er && !o_rx_dv))
        else $error("false carrier count without error nibbles");
    bad_nibble_a: assert property (
        o_rx_er && !o_rx_dv |-> o_rxd == 4'hE)
        else $error("bad start nibble wrong");
    carrier_a: assert property (
        o_rx_dv || o_rx_er |-> o_crs)
        else $error("valid or error without carrier");
    ctrl_nibble_a: assert property (
        o_rx_dv && o_rx_er |-> o_rxd == 4'h0)
        else $error("invalid code nibble wrong");
    preamble_a: assert property (
        $rose(o_rx_dv) |-> o_rxd == 4'h5 && !o_rx_er)
        else $error("frame does not open with preamble");
    out_hold_a: assert property (
        !$past(i_mii_ready) |-> $stable({o_rxd, o_rx_dv, o_rx_er, o_crs}))
        else $error("receive outputs changed while not taken");
    link_wait_a: assert property (
        $rose(o_link_up) |->
        sd_run_q >= LINK_CYC && sd_run_q <= LINK_CYC + 8)
        else $error("link up at wrong signal detect time");
    link_drop_a: assert property (
        $fell(i_sig_det) |-> ##[1:5] !o_link_up)
        else $error("link kept after signal detect loss");
    lock_link_a: assert property (
        $rose(o_locked) |-> o_link_up)
        else $error("lock gained without link");
    lock_clear_a: assert property (
        $fell(o_link_up) |-> ##[0:2] !o_locked)
        else $error("lock kept after link loss");
    fiber_wr_a: assert property (
        i_fiber_wr |=> o_fiber_mode == $past(i_fiber_wdata))
        else $error("fiber mode write not taken");

    frame_c: cover property ($rose(o_rx_dv));
    bad_c: cover property (o_rx_er && !o_rx_dv);
    unlock_c: cover property ($fell(o_locked));
    full_c: cover property (!o_fifo_ready);
endmodule

bind frx_pcs frx_pcs_sva #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC))
    i_frx_pcs_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sig_det(i_sig_det), .i_fiber_wr(i_fiber_wr),
    .i_fiber_wdata(i_fiber_wdata), .i_mii_ready(i_mii_ready),
    .o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_crs(o_crs),
    .o_fifo_ready(o_fifo_ready), .o_link_up(o_link_up),
    .o_locked(o_locked), .o_fiber_mode(o_fiber_mode),
    .o_false_carrier_event_counter(o_false_carrier_event_counter));

// [verif/frx_pcs_tb_top.sv]
`include "frx_defines.vh"
module frx_pcs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LINK = 50;
    logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic        clk, reset_n, ce, sig_det, strap, fwr, fwdata, stall, scr;
    logic [4:0]  rx_bits, fill;
    logic [10:0] key_q = 11'h5A5;
    logic        bitq[$];
    wire  [3:0]  rxd;
    wire  [15:0] fc_cnt;
    wire         rx_dv, rx_er, crs, fifo_ready, link_up, locked, fmode, rdy;
    int          miscompares = 0;
    int          comparisons = 0;

    frx_pcs #(.HOLD_CYC(200), .LINK_CYC(LINK)) i_frx_pcs (
        .i_clk(clk), .i_reset_n(reset_n), .i_ce(ce), .i_rx_bits(rx_bits),
        .i_sig_det(sig_det), .i_fiber_strap(strap), .i_fiber_wr(fwr),
        .i_fiber_wdata(fwdata), .i_mii_ready(rdy), .o_rxd(rxd),
        .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs),
        .o_fifo_ready(fifo_ready), .o_link_up(link_up), .o_locked(locked),
        .o_fiber_mode(fmode), .o_false_carrier_event_counter(fc_cnt));
    frx_mii_sink i_frx_mii_sink (
        .i_clk(clk), .i_reset_n(reset_n), .i_stall(stall), .i_rxd(rxd),
        .i_rx_dv(rx_dv), .i_rx_er(rx_er), .i_crs(crs), .o_mii_ready(rdy));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Line bits go out oldest first in bit 4; an empty queue sends the filler
    always @(negedge clk) begin
        if (scr && bitq.size() == 0) push_scr(fill);
        if (bitq.size() >= 5) begin
            for (int i = 4; i >= 0; i--) rx_bits[i] = bitq.pop_front();
        end else begin
            rx_bits = fill;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic push(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) bitq.push_back(cg[i]);
    endtask
    task automatic push_scr(input logic [4:0] cg);
        logic n;
        for (int i = 4; i >= 0; i--) begin
            n = key_q[10] ^ key_q[8];
            key_q = {key_q[9:0], n};
            bitq.push_back(cg[i] ^ n);
        end
    endtask
    task automatic settle();
        for (int k = 0; k < 4000 && bitq.size() > 0; k++) @(negedge clk);
        repeat (30) @(negedge clk);
    endtask
    task automatic send_frame(input int off, input int n);
        repeat (off) bitq.push_back(1'b1);
        repeat (2) push(`FRX_CG_IDLE);
        push(`FRX_CG_J);
        push(`FRX_CG_K);
        for (int k = 0; k < n; k++) push(enc[k]);
        push(`FRX_CG_T);
        push(`FRX_CG_R);
        repeat ((5 - off) % 5) bitq.push_back(1'b1);
        repeat (4) push(`FRX_CG_IDLE);
        settle();
    endtask
    task automatic check_frame(input int cnt);
        chk(16'(i_frx_mii_sink.got_q.size()), 16'(cnt), "entry count");
        for (int k = 0; k < cnt && k < i_frx_mii_sink.got_q.size(); k++)
            chk(16'(i_frx_mii_sink.got_q[k]),
                16'((k < 2) ? 7'h65 : 7'h60 + k - 2), "frame entry");
        i_frx_mii_sink.got_q.delete();
    endtask

    task automatic t_start();
        repeat (3) @(negedge clk);
        chk({rx_dv, rx_er, crs, link_up, locked, fmode}, 0, "reset state");
        chk(fc_cnt, 0, "count after reset");
        sig_det = 1'b1;
        repeat (LINK - 1) @(negedge clk);
        chk(link_up, 0, "link up early");
        repeat (12) @(negedge clk);
        chk(link_up, 1, "link not up");
        $display("done: reset and link");
    endtask
    task automatic t_copper();
        scr = 1'b1;
        repeat (40) push_scr(`FRX_CG_IDLE);
        settle();
        chk(locked, 1, "no lock on idle");
        repeat (300) push_scr(`FRX_CG_IDLE);
        settle();
        chk(locked, 1, "lock lost on idle");
        fill = 5'h00;
        repeat (260) push_scr(5'h00);
        settle();
        chk(locked, 0, "lock kept without idle");
        fwdata = 1'b1;
        fwr = 1'b1;
        @(negedge clk);
        fwr = 1'b0;
        fill = `FRX_CG_IDLE;
        scr = 1'b0;
        repeat (30) @(negedge clk);
        chk(fmode, 1, "fiber mode not set");
        i_frx_mii_sink.got_q.delete();
        $display("done: descrambler lock");
    endtask
    task automatic t_frames();
        send_frame(0, 16);
        check_frame(18);
        send_frame(2, 16);
        check_frame(18);
        repeat (2) push(`FRX_CG_IDLE);
        push(`FRX_CG_J);
        push(`FRX_CG_K);
        push(enc[3]);
        push(`FRX_CG_K);
        send_frame(0, 0);
        chk(16'(i_frx_mii_sink.got_q[3]), 16'h0070, "control in data");
        i_frx_mii_sink.got_q.delete();
        repeat (2) push(`FRX_CG_IDLE);
        push(`FRX_CG_J);
        push(`FRX_CG_K);
        push(enc[1]);
        repeat (4) push(`FRX_CG_IDLE);
        settle();
        chk(i_frx_mii_sink.got_q.size() inside {3, 4}, 1, "idle end");
        chk(16'(i_frx_mii_sink.got_q[2]), 16'h0061, "last nibble");
        i_frx_mii_sink.got_q.delete();
        $display("done: frames");
    endtask
    task automatic t_bad();
        logic [15:0] c0;
        for (int r = 0; r < 2; r++) begin
            c0 = fc_cnt;
            repeat (2) push(`FRX_CG_IDLE);
            push((r != 0) ? `FRX_CG_J : enc[5]);
            repeat (2) push(enc[5]);
            repeat (4) push(`FRX_CG_IDLE);
            settle();
            chk(fc_cnt, c0 + 16'h0001, "false carrier count");
            chk(i_frx_mii_sink.got_q.size() inside {3, 4}, 1, "length");
            foreach (i_frx_mii_sink.got_q[k])
                chk(16'(i_frx_mii_sink.got_q[k]), 16'h005E, "bad");
            chk({rx_er, crs}, 0, "error held after idle");
            i_frx_mii_sink.got_q.delete();
        end
        $display("done: bad start");
    endtask
    task automatic t_fifo();
        stall = 1'b1;
        send_frame(0, 16);
        chk(fifo_ready, 0, "buffer never full");
        stall = 1'b0;
        repeat (30) @(negedge clk);
        chk(fifo_ready, 1, "buffer not drained");
        check_frame(8);
        $display("done: buffer");
    endtask
    task automatic t_drop();
        sig_det = 1'b0;
        repeat (6) @(negedge clk);
        chk({link_up, locked}, 0, "link or lock kept");
        send_frame(0, 4);
        chk(16'(i_frx_mii_sink.got_q.size()), 0, "data without link");
        sig_det = 1'b1;
        repeat (LINK + 12) @(negedge clk);
        chk(link_up, 1, "link not back");
        strap = 1'b1;
        @(negedge clk);
        reset_n = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(fmode, 1, "strap not taken");
        chk(fc_cnt, 0, "count not cleared");
        $display("done: link loss and strap");
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge clk);
        miscompares++;
        $display("unexpected at %0t: run did not finish", $time);
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        sig_det = 1'b0;
        strap = 1'b0;
        fwr = 1'b0;
        fwdata = 1'b0;
        stall = 1'b0;
        scr = 1'b0;
        fill = `FRX_CG_IDLE;
        rx_bits = `FRX_CG_IDLE;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        t_start();
        t_copper();
        t_frames();
        t_bad();
        t_fifo();
        t_drop();
        test_done();
    end
endmodule
